// ---- hdl/rtcp_map.svh ----
// Constants for the real-time counter with periodic timer.
`ifndef RTCP_MAP_SVH
`define RTCP_MAP_SVH
`define RTCP_CNT_W 16
`define RTCP_PRE_W 15
`define RTCP_CNT_RST 16'h0000
`define RTCP_PRE_RST 15'h0000
`define RTCP_SRC_OSC 2'h0
`define RTCP_SRC_DIV32 2'h1
`define RTCP_SRC_EXT 2'h3
`define RTCP_DIV32_LAST 5'h0f
`define RTCP_PER_OFF 4'h0
`define RTCP_PER_MIN 4'h1
`define RTCP_PER_MAX 4'he
`define RTCP_EV_LOW_BIT 5
`define RTCP_EV_CNT 8
`define RTCP_PRESC_MAX 4'hf
`endif

// ---- hdl/rtcp_pkg.sv ----
// Types shared by the real-time counter block.
package rtcp_pkg;
  typedef enum logic [1:0] {
    RTCP_SRC_OSC_E,
    RTCP_SRC_DIV32_E,
    RTCP_SRC_RSVD_E,
    RTCP_SRC_EXT_E
  } rtcp_src_e;
endpackage

// ---- hdl/rtcp_core.sv ----
// Real-time counter and periodic timer sharing one prescaler.
//
// What this block does
// - Counter advances per prescaled tick and compares against period and compare values.
// - Compare flag and event raised on first tick after counter equals compare.
// - Overflow flag and event raised on first tick after counter equals period.
// - Overflow wraps the counter back to zero.
// - Clock source is external clock, 32 kHz oscillator, or oscillator divided by 32.
// - A 15-bit prescaler counter divides the selected clock.
// - Periodic timer enables independently of the main counter.
// - Periodic interrupt every n cycles, n a power of two from 4 to 32768.
// - Counter enable bit at one runs the counter, at zero stops it.
// - Periodic enable bit at one runs the timer, at zero stops it.
// - Both share the prescaler; prescaler select and period field act independently.
// - Prescaler cleared and stopped when neither counter nor timer runs, counting when either runs.
// - Periodic alone starts prescaler from zero; output rises after half period.
// - With counter running, first periodic output comes within one interval.
// - Periodic output then toggles every half interval.
// - Sixteen-cycle interval makes output equal prescaler bit three.
// - Overflow event is a one slow-cycle strobe when the counter wraps.
// - Compare event is a one slow-cycle strobe on match.
// - Eight periodic event square waves, period 8192 halving down to 64.
// - Counter and timer halt while the debugger halts the CPU, each unless its own run-while-halted bit is set.
// - Interrupt request stays active while flag and enable are both set.
// - Separate busy indications for compare, period, count, control, periodic control.
// - Counter runs in idle, in standby only with run-in-standby; timer always.
`timescale 1ns/100ps
`include "rtcp_map.svh"

module rtcp_core #(
  parameter int CNT_W = `RTCP_CNT_W,
  parameter int PRE_W = `RTCP_PRE_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Slow clock sources, sampled as synchronous levels.
  input wire logic extClk,
  input wire logic oscClk,
  // Counter configuration.
  input wire logic counterEnable,
  input wire logic [3:0] prescalerSelect,
  input wire logic [1:0] clockSourceSelect,
  input wire logic [CNT_W-1:0] periodValue,
  input wire logic [CNT_W-1:0] compareValue,
  input wire logic countWrite,
  input wire logic [CNT_W-1:0] countWriteData,
  input wire logic runInStandby,
  input wire logic runWhileHalted,
  // Periodic timer configuration.
  input wire logic periodicEnable,
  input wire logic [3:0] periodicPeriod,
  input wire logic periodicRunWhileHalted,
  // System state.
  input wire logic cpuHalted,
  input wire logic sleepStandby,
  // Interrupt control.
  input wire logic compareIrqEnable,
  input wire logic overflowIrqEnable,
  input wire logic periodicIrqEnable,
  input wire logic compareFlagClear,
  input wire logic overflowFlagClear,
  input wire logic periodicFlagClear,
  // Status and results.
  output logic [CNT_W-1:0] countValue,
  output logic compareFlag,
  output logic overflowFlag,
  output logic periodicFlag,
  output logic counterIrq,
  output logic periodicIrq,
  output logic compareEvent,
  output logic overflowEvent,
  output logic [`RTCP_EV_CNT-1:0] periodicEvents,
  output logic periodicOut,
  output logic compareSyncPending,
  output logic periodSyncPending,
  output logic countSyncPending,
  output logic controlSyncPending,
  output logic periodicSyncPending
);

  ////////////////////////////////////////////////////////////////////////////////
  // Slow clock selection and edge detection.

  logic srcLvl;
  logic srcPrev_r;
  logic oscPrev_r;
  logic div32Lvl_r;
  logic [4:0] div32Cnt_r;
  logic slowTick;
  logic oscRise;

  assign oscRise = oscClk & ~oscPrev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev_r <= 1'b0;
      div32Cnt_r <= 5'h00;
      div32Lvl_r <= 1'b0;
    end else begin
      oscPrev_r <= oscClk;
      // Toggling every sixteen rises gives one full level period per 32 oscillator periods.
      if (oscRise) begin
        if (div32Cnt_r == `RTCP_DIV32_LAST) begin
          div32Cnt_r <= 5'h00;
          div32Lvl_r <= ~div32Lvl_r;
        end else begin
          div32Cnt_r <= div32Cnt_r + 5'h01;
        end
      end
    end
  end

  always_comb begin
    unique case (rtcp_pkg::rtcp_src_e'(clockSourceSelect))
      rtcp_pkg::RTCP_SRC_OSC_E: srcLvl = oscClk;
      rtcp_pkg::RTCP_SRC_DIV32_E: srcLvl = div32Lvl_r;
      rtcp_pkg::RTCP_SRC_EXT_E: srcLvl = extClk;
      default: srcLvl = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcPrev_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLvl;
    end
  end

  assign slowTick = srcLvl & ~srcPrev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Run qualifiers: debug halt and sleep.

  logic cntRun;
  logic pitRun;
  logic preRun;

  // Standby only stops the counter; the periodic timer keeps running in any sleep.
  assign cntRun = counterEnable & (~cpuHalted | runWhileHalted)
      & (~sleepStandby | runInStandby);
  assign pitRun = periodicEnable & (~cpuHalted | periodicRunWhileHalted);
  assign preRun = cntRun | pitRun;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared 15-bit prescaler.

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] preNxt;
  logic cntTick;

  assign preNxt = pre_r + PRE_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= `RTCP_PRE_RST;
    end else if (!preRun) begin
      pre_r <= `RTCP_PRE_RST;
    end else if (slowTick) begin
      pre_r <= preNxt;
    end
  end

  // Divide by 2^prescalerSelect: tick when the low bits of the prescaler roll over.
  always_comb begin
    cntTick = 1'b0;
    if (slowTick && cntRun) begin
      if (prescalerSelect == 4'h0) begin
        cntTick = 1'b1;
      end else if (prescalerSelect < `RTCP_PRESC_MAX) begin
        cntTick = (preNxt & ((PRE_W'(1) << prescalerSelect) - PRE_W'(1))) == '0;
      end else begin
        cntTick = (preNxt == '0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main counter, compare and overflow.

  logic [CNT_W-1:0] cnt_r;
  logic matchHit;
  logic wrapHit;

  assign matchHit = cntTick && (cnt_r == compareValue);
  assign wrapHit = cntTick && (cnt_r == periodValue);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= `RTCP_CNT_RST;
    end else if (countWrite) begin
      cnt_r <= countWriteData;
    end else if (wrapHit) begin
      cnt_r <= `RTCP_CNT_RST;
    end else if (cntTick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign countValue = cnt_r;

  // Strobes last one slow-clock cycle: held from the tick to the next slow edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compareEvent <= 1'b0;
      overflowEvent <= 1'b0;
    end else if (slowTick) begin
      compareEvent <= matchHit;
      overflowEvent <= wrapHit;
    end else if (!cntRun) begin
      compareEvent <= 1'b0;
      overflowEvent <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Periodic timer output and events.

  logic pitLvl;
  logic pitPrev_r;
  logic pitRise;

  // Interval 2^(periodicPeriod+1): output follows prescaler bit periodicPeriod.
  always_comb begin
    pitLvl = 1'b0;
    if (pitRun && periodicPeriod >= `RTCP_PER_MIN && periodicPeriod <= `RTCP_PER_MAX) begin
      pitLvl = pre_r[periodicPeriod];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pitPrev_r <= 1'b0;
      periodicOut <= 1'b0;
    end else begin
      pitPrev_r <= pitLvl;
      periodicOut <= pitLvl;
    end
  end

  assign pitRise = pitLvl & ~pitPrev_r;

  genvar gi;
  generate
    for (gi = 0; gi < `RTCP_EV_CNT; gi++) begin : g_ev
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          periodicEvents[gi] <= 1'b0;
        end else begin
          periodicEvents[gi] <= pitRun & pre_r[`RTCP_EV_LOW_BIT + `RTCP_EV_CNT - 1 - gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags and interrupt requests; a set beats a same-cycle clear.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compareFlag <= 1'b0;
      overflowFlag <= 1'b0;
      periodicFlag <= 1'b0;
    end else begin
      compareFlag <= matchHit | (compareFlag & ~compareFlagClear);
      overflowFlag <= wrapHit | (overflowFlag & ~overflowFlagClear);
      periodicFlag <= pitRise | (periodicFlag & ~periodicFlagClear);
    end
  end

  assign counterIrq = (compareFlag & compareIrqEnable) | (overflowFlag & overflowIrqEnable);
  assign periodicIrq = periodicFlag & periodicIrqEnable;

  ////////////////////////////////////////////////////////////////////////////////
  // Busy indications: a configuration change is pending until the next slow edge.

  logic [CNT_W-1:0] compareSeen_r;
  logic [CNT_W-1:0] periodSeen_r;
  logic [7:0] ctrlSeen_r;
  logic [4:0] pitSeen_r;
  logic cntPend_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compareSeen_r <= `RTCP_CNT_RST;
      periodSeen_r <= `RTCP_CNT_RST;
      ctrlSeen_r <= 8'h00;
      pitSeen_r <= 5'h00;
      cntPend_r <= 1'b0;
    end else begin
      if (slowTick) begin
        compareSeen_r <= compareValue;
        periodSeen_r <= periodValue;
        ctrlSeen_r <= {runInStandby, clockSourceSelect, prescalerSelect, counterEnable};
        pitSeen_r <= {periodicPeriod, periodicEnable};
      end
      cntPend_r <= countWrite | (cntPend_r & ~slowTick);
    end
  end

  // Pending clears only at a slow tick, so a stopped slow source leaves it set.
  assign compareSyncPending = (compareSeen_r != compareValue);
  assign periodSyncPending = (periodSeen_r != periodValue);
  assign countSyncPending = cntPend_r;
  assign controlSyncPending = ctrlSeen_r !=
      {runInStandby, clockSourceSelect, prescalerSelect, counterEnable};
  assign periodicSyncPending = (pitSeen_r != {periodicPeriod, periodicEnable});

endmodule // rtcp_core

// ---- tb/rtcp_core_props.sv ----
// Port assertions for the real-time counter with periodic timer.
`timescale 1ns/100ps
module rtcp_core_props #(parameter int CNT_W = 16) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched.
  input wire logic oscClk,
  input wire logic counterEnable,
  input wire logic [3:0] prescalerSelect,
  input wire logic [1:0] clockSourceSelect,
  input wire logic [CNT_W-1:0] periodValue,
  input wire logic [CNT_W-1:0] compareValue,
  input wire logic countWrite,
  input wire logic cpuHalted,
  input wire logic sleepStandby,
  input wire logic runInStandby,
  input wire logic compareIrqEnable,
  input wire logic overflowIrqEnable,
  input wire logic overflowFlagClear,
  // Outputs watched.
  input wire logic [CNT_W-1:0] countValue,
  input wire logic compareFlag,
  input wire logic overflowFlag,
  input wire logic counterIrq,
  input wire logic compareEvent,
  input wire logic overflowEvent
);
  logic oscPrev_r;
  logic valid_r;
  logic tick;
  logic run;
  // The first cycle after reset is skipped, since the previous source level is unknown there.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      oscPrev_r <= oscClk;
      valid_r <= 1'b1;
    end
  end
  assign tick = valid_r && oscClk && !oscPrev_r;
  // Standby without its run bit stops the counter legitimately.
  assign run = tick && clockSourceSelect == 2'h0 && counterEnable && prescalerSelect == 4'h0
    && !cpuHalted && !countWrite && (!sleepStandby || runInStandby);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_inc;
    run && countValue != periodValue |=> countValue == $past(countValue) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("Counter did not advance");
  property p_wrap;
    run && countValue == periodValue |=> countValue == 16'h0000 && overflowFlag && overflowEvent;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Bad wrap");
  property p_cmp;
    run && countValue == compareValue |=> compareFlag && compareEvent;
  endproperty
  a_cmp: assert property (p_cmp) else $error("Missed compare");
  property p_hold;
    valid_r && clockSourceSelect == 2'h0 && !tick && !countWrite |=> $stable(countValue);
  endproperty
  a_hold: assert property (p_hold) else $error("Count moved without tick");
  property p_stop;
    !counterEnable && !countWrite |=> $stable(countValue);
  endproperty
  a_stop: assert property (p_stop) else $error("Count moved while off");
  property p_keep;
    overflowFlag && !overflowFlagClear |=> overflowFlag;
  endproperty
  a_keep: assert property (p_keep) else $error("Flag lost");
  property p_clr;
    valid_r && clockSourceSelect == 2'h0 && overflowFlagClear && !tick |=> !overflowFlag;
  endproperty
  a_clr: assert property (p_clr) else $error("Flag not cleared");
  property p_irq;
    counterIrq == (compareFlag && compareIrqEnable || overflowFlag && overflowIrqEnable);
  endproperty
  a_irq: assert property (p_irq) else $error("Bad request");
endmodule // rtcp_core_props
bind rtcp_core rtcp_core_props #(.CNT_W(CNT_W)) u_rtcp_core_props (.clk, .rst_n, .oscClk,
  .counterEnable, .prescalerSelect, .clockSourceSelect, .periodValue, .compareValue,
  .countWrite, .cpuHalted, .sleepStandby, .runInStandby, .compareIrqEnable,
  .overflowIrqEnable, .overflowFlagClear,
  .countValue, .compareFlag, .overflowFlag, .counterIrq, .compareEvent, .overflowEvent);

// ---- tb/rtcp_slow_clk_model.sv ----
// Slow oscillator and external clock sources feeding the counter.
`timescale 1ns/100ps
module rtcp_slow_clk_model #(parameter int HALF = 4) (
  // Reference clock.
  input wire logic clk,
  // Slow clock sources.
  output logic oscClk,
  output logic extClk
);
  // Both step off clk, so tick spacing is exact in clk cycles.
  initial begin
    oscClk = 1'b0;
    extClk = 1'b0;
    forever begin
      repeat (HALF) @(posedge clk);
      #1;
      oscClk = ~oscClk;
      extClk = oscClk ^ extClk;
    end
  end
endmodule // rtcp_slow_clk_model

// ---- tb/tb_rtcp_core.sv ----
// Self-checking bench for the real-time counter with periodic timer.
`timescale 1ns/100ps
module tb_rtcp_core;
  logic clk, rst_n, extClk, oscClk, counterEnable, countWrite, runInStandby, runWhileHalted;
  logic periodicEnable, periodicRunWhileHalted, cpuHalted, sleepStandby, compareIrqEnable;
  logic overflowIrqEnable, periodicIrqEnable, compareFlagClear, overflowFlagClear;
  logic periodicFlagClear, compareFlag, overflowFlag, periodicFlag, counterIrq, periodicIrq;
  logic compareEvent, overflowEvent, periodicOut, compareSyncPending, periodSyncPending;
  logic countSyncPending, controlSyncPending, periodicSyncPending;
  logic [3:0] prescalerSelect, periodicPeriod;
  logic [1:0] clockSourceSelect;
  logic [15:0] periodValue, compareValue, countWriteData, countValue;
  logic [7:0] periodicEvents;
  int num_errors, checks, cycles;

  rtcp_slow_clk_model u_rtcp_slow_clk_model (.clk, .oscClk, .extClk);
  rtcp_core u_rtcp_core (.clk, .rst_n, .extClk, .oscClk, .counterEnable, .prescalerSelect,
    .clockSourceSelect, .periodValue, .compareValue, .countWrite, .countWriteData,
    .runInStandby, .runWhileHalted, .periodicEnable, .periodicPeriod, .periodicRunWhileHalted,
    .cpuHalted, .sleepStandby, .compareIrqEnable, .overflowIrqEnable, .periodicIrqEnable,
    .compareFlagClear, .overflowFlagClear, .periodicFlagClear, .countValue, .compareFlag,
    .overflowFlag, .periodicFlag, .counterIrq, .periodicIrq, .compareEvent, .overflowEvent,
    .periodicEvents, .periodicOut, .compareSyncPending, .periodSyncPending, .countSyncPending,
    .controlSyncPending, .periodicSyncPending);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Waits up to 100 cycles until no synchronisation is pending.
  task automatic syncWait();
    int i;
    for (i = 0; i < 100 && (|{compareSyncPending, periodSyncPending, countSyncPending,
        controlSyncPending, periodicSyncPending}) !== 1'b0; i++) step(1);
  endtask

  function automatic logic pick(input int b);
    return b > 7 ? periodicOut : periodicEvents[b];
  endfunction

  // The first change is only a phase marker; the second interval is the measured half.
  task automatic halfLen(input int b, output int n);
    logic v;
    v = pick(b);
    for (n = 0; n < 600 && pick(b) === v; n++) step(1);
    v = pick(b);
    for (n = 0; n < 600 && pick(b) === v; n++) step(1);
  endtask

  task automatic testCounter();
    int n;
    logic [15:0] held;
    // Clock source and values, then interrupt enables with counter enable; prescaler stays at zero.
    clockSourceSelect = 2'h0;
    periodValue = 16'h0003;
    compareValue = 16'h0002;
    #1;
    chk(compareSyncPending, 16'h0001);
    syncWait();
    compareIrqEnable = 1'b1;
    overflowIrqEnable = 1'b1;
    counterEnable = 1'b1;
    for (n = 0; n < 200 && overflowFlag !== 1'b1; n++) step(1);
    chk(countValue, 16'h0000);
    chk(overflowEvent, 16'h0001);
    chk(compareFlag, 16'h0001);
    chk(counterIrq, 16'h0001);
    overflowFlagClear = 1'b1;
    step(1);
    overflowFlagClear = 1'b0;
    compareFlagClear = 1'b1;
    chk(overflowFlag, 16'h0000);
    step(1);
    compareFlagClear = 1'b0;
    chk(counterIrq, 16'h0000);
    step(7);
    chk(overflowEvent, 16'h0000);
    cpuHalted = 1'b1;
    held = countValue;
    step(40);
    chk(countValue, held);
    runWhileHalted = 1'b1;
    step(40);
    chk(countValue == held, 16'h0000);
    cpuHalted = 1'b0;
    counterEnable = 1'b0;
    step(2);
    held = countValue;
    step(40);
    chk(countValue, held);
  endtask

  task automatic testPeriodic();
    int n;
    int p;
    // Interrupt enable first, then interval together with enable.
    periodicIrqEnable = 1'b1;
    syncWait();
    periodicPeriod = 4'h1;
    periodicEnable = 1'b1;
    for (n = 0; n < 100 && periodicOut !== 1'b1; n++) step(1);
    chk(n >= 9 && n <= 27, 16'h0001);
    step(1);
    chk(periodicIrq, 16'h0001);
    periodicFlagClear = 1'b1;
    step(1);
    periodicFlagClear = 1'b0;
    chk(periodicIrq, 16'h0000);
    for (p = 1; p < 5; p++) begin
      periodicPeriod = 4'(p);
      halfLen(8, n);
      chk(16'(n), 16'h0008 << p);
    end
    for (p = 6; p < 8; p++) begin
      halfLen(p, n);
      chk(16'(n), 16'h0100 << (7 - p));
    end
    periodicEnable = 1'b0;
    step(3);
    chk({periodicEvents, periodicOut}, 16'h0000);
  endtask

  // Cycles between two count steps; the first step only marks the phase.
  task automatic countGap(output int n);
    logic [15:0] held;
    held = countValue;
    for (n = 0; n < 600 && countValue === held; n++) step(1);
    held = countValue;
    for (n = 0; n < 600 && countValue === held; n++) step(1);
  endtask

  task automatic testModes();
    int n;
    syncWait();
    countWriteData = 16'h0005;
    countWrite = 1'b1;
    step(1);
    countWrite = 1'b0;
    chk(countValue, 16'h0005);
    chk(countSyncPending, 16'h0001);
    periodValue = 16'hffff;
    #1;
    chk(periodSyncPending, 16'h0001);
    syncWait();
    sleepStandby = 1'b1;
    counterEnable = 1'b1;
    step(40);
    chk(countValue, 16'h0005);
    runInStandby = 1'b1;
    step(40);
    chk(countValue == 16'h0005, 16'h0000);
    sleepStandby = 1'b0;
    prescalerSelect = 4'h2;
    #1;
    chk(controlSyncPending, 16'h0001);
    countGap(n);
    chk(16'(n), 16'h0020);
    prescalerSelect = 4'h0;
    clockSourceSelect = 2'h1;
    countGap(n);
    chk(16'(n), 16'h0100);
    clockSourceSelect = 2'h3;
    countGap(n);
    chk(16'(n), 16'h0010);
    counterEnable = 1'b0;
  endtask

  initial begin
    {rst_n, counterEnable, countWrite, runInStandby, runWhileHalted, periodicEnable} = '0;
    {periodicRunWhileHalted, cpuHalted, sleepStandby, compareIrqEnable} = '0;
    {overflowIrqEnable, periodicIrqEnable, compareFlagClear, overflowFlagClear} = '0;
    periodicFlagClear = 1'b0;
    {prescalerSelect, periodicPeriod, clockSourceSelect} = '0;
    {periodValue, compareValue, countWriteData} = '0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    chk(countValue, 16'h0000);
    testCounter();
    testPeriodic();
    testModes();
    summarize();
  end
endmodule // tb_rtcp_core
